/* hdl/mbf_defines.svh */
`ifndef MBF_DEFINES_SVH
`define MBF_DEFINES_SVH
// function codes and diagnostics sub-functions
`define MBF_FC_RD_HOLD 8'h03
`define MBF_FC_RD_INPUT 8'h04
`define MBF_FC_WR_ONE 8'h06
`define MBF_FC_DIAG 8'h08
`define MBF_FC_WR_MULTI 8'h10
`define MBF_FC_RD_WR 8'h17
`define MBF_SUB_ECHO 16'h0000
`define MBF_SUB_DREG 16'h0002
// station address and exception answers
`define MBF_BCAST 8'h00
`define MBF_EXC_FLAG 8'h80
`define MBF_EXC_FUNC 8'h01
`define MBF_EXC_ADDR 8'h02
`define MBF_EXC_VALUE 8'h03
// per-telegram register limits
`define MBF_MAX_RD 16'h007D
`define MBF_MAX_WR 16'h0078
`define MBF_MAX_RW 16'h0076
// byte positions and fixed lengths
`define MBF_FIX_LEN 9'h006
`define MBF_EXC_LEN 9'h003
`define MBF_RD_DATA 9'h003
`define MBF_WM_DATA 9'h007
`define MBF_RW_DATA 9'h00B
`define MBF_BUF_LEN 9'h100
// timing
`define MBF_CLK_MHZ 40
`define MBF_RSP_TIME_US 3000
`define MBF_RSP_CYC (`MBF_RSP_TIME_US * `MBF_CLK_MHZ)
`define MBF_TMO_TIME_US 100000
`define MBF_TMO_CYC (`MBF_TMO_TIME_US * `MBF_CLK_MHZ)
`endif

/* hdl/mbf_pkg.sv */
package mbf_pkg;
	typedef logic [7:0] mbf_byte_t;
	typedef logic [15:0] mbf_word_t;
	typedef enum logic [2:0] {DEV_RX, DEV_CHECK, DEV_WRITE, DEV_WAIT, DEV_SEND} mbf_dev_state_t;
	typedef enum logic [1:0] {MST_IDLE, MST_SEND, MST_WAIT} mbf_mst_state_t;
	// register count within 1..limit
	function automatic logic mbfQtyOk(input mbf_word_t qty, input mbf_word_t lim);
		mbfQtyOk = (qty != 16'h0000) && (qty <= lim);
	endfunction : mbfQtyOk
endpackage : mbf_pkg

/* hdl/mbf_link_if.sv */
`timescale 1ns/10ps
interface mbf_link_if;
	// request telegram bytes, master to device
	logic reqValid;
	logic [7:0] reqData;
	logic reqLast;
	// response telegram bytes, device to master
	logic rspValid;
	logic [7:0] rspData;
	logic rspLast;
	modport dev (input reqValid, reqData, reqLast, output rspValid, rspData, rspLast);
	modport mst (output reqValid, reqData, reqLast, input rspValid, rspData, rspLast);
endinterface : mbf_link_if

/* hdl/mbf_dev_end.sv */
`timescale 1ns/10ps
// Notes on behaviour
// RL1: reads take 1..125 registers, two bytes each
// RL2: codes 03 and 04 answer identically
// RL3: code 06 writes exactly one register
// RL4: diagnostics sub 0 echoes, sub 2 returns register
// RL5: code 16 writes 1..120 registers
// RL6: code 23 handles at most 118 registers
// RL7: code 23 writes before it reads
// RL8: broadcast only with codes 06, 16, 23
// RL9: answer starts 3 ms after request end
// RL10: bad code or length gets exception answer
// RL11: broadcasts execute but never answer
`include "mbf_defines.svh"
module mbf_dev_end #(
	parameter int REG_COUNT = 128,
	parameter int RSP_CYC = `MBF_RSP_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// link to the master
	mbf_link_if.dev link,
	// station settings
	input wire mbf_pkg::mbf_byte_t ownAddr,
	input wire mbf_pkg::mbf_word_t diagWord,
	// register write events
	output logic regWrPulse,
	output mbf_pkg::mbf_word_t regWrAddr,
	output mbf_pkg::mbf_word_t regWrData
);
	import mbf_pkg::*;
	localparam int IW = $clog2(REG_COUNT);
	localparam int DW = $clog2(RSP_CYC + 1);

	mbf_dev_state_t state_reg, state_next;
	mbf_byte_t rxBuf [0:255];
	mbf_word_t regFile [0:REG_COUNT-1];
	logic [8:0] rxCnt_reg;
	logic [7:0] wrIdx_reg;
	logic [DW-1:0] dly_reg;
	logic [8:0] txIdx_reg;
	mbf_byte_t excCode_reg;
	logic rspValid_reg, rspLast_reg, regWrPulse_reg;
	mbf_byte_t rspData_reg;
	mbf_word_t regWrAddr_reg, regWrData_reg;
	mbf_byte_t exc, txByte;

	// range check against the register file
	function automatic logic fits(input mbf_word_t start, input mbf_word_t qty);
		fits = ({1'b0, start} + {1'b0, qty}) <= 17'(REG_COUNT);
	endfunction : fits

	// request field decode
	wire mbf_byte_t dst = rxBuf[0];
	wire mbf_byte_t fc = rxBuf[1];
	wire mbf_word_t w1 = {rxBuf[2], rxBuf[3]};
	wire mbf_word_t w2 = {rxBuf[4], rxBuf[5]};
	wire mbf_word_t w3 = {rxBuf[6], rxBuf[7]};
	wire mbf_word_t w4 = {rxBuf[8], rxBuf[9]};
	wire mbf_byte_t bc16 = rxBuf[6];
	wire mbf_byte_t bc23 = rxBuf[10];
	wire isBcast = (dst == `MBF_BCAST);
	wire forMe = isBcast || (dst == ownAddr);
	wire isRead = (fc == `MBF_FC_RD_HOLD) || (fc == `MBF_FC_RD_INPUT); // RL2
	wire isWr1 = (fc == `MBF_FC_WR_ONE);
	wire isWrN = (fc == `MBF_FC_WR_MULTI);
	wire isRw = (fc == `MBF_FC_RD_WR);
	wire isDiag = (fc == `MBF_FC_DIAG);
	wire isEcho = isDiag && (w1 == `MBF_SUB_ECHO);
	wire bcastOk = isWr1 || isWrN || isRw; // RL8
	wire doWrite = (exc == 8'h00) && bcastOk;

	// write walk: start, count and data position
	wire mbf_word_t wrStart = isRw ? w3 : w1;
	wire mbf_word_t wrQty = isRw ? w4 : (isWrN ? w2 : 16'h0001); // RL3
	wire [8:0] wrBase = isRw ? `MBF_RW_DATA : (isWrN ? `MBF_WM_DATA : 9'h004);
	wire [8:0] wrPos = wrBase + {wrIdx_reg, 1'b0};
	wire mbf_word_t wrWord = {rxBuf[wrPos[7:0]], rxBuf[wrPos[7:0] + 8'h01]};
	wire mbf_word_t wrAddr = wrStart + {8'h00, wrIdx_reg};
	wire wrDone = ({8'h00, wrIdx_reg} == wrQty - 16'h0001);

	// request checks and exception code
	always_comb begin
		exc = 8'h00;
		if (isRead) begin
			if (rxCnt_reg != `MBF_FIX_LEN || !mbfQtyOk(w2, `MBF_MAX_RD)) // RL1
				exc = `MBF_EXC_VALUE; // RL10
			else if (!fits(w1, w2))
				exc = `MBF_EXC_ADDR;
		end else if (isWr1) begin
			if (rxCnt_reg != `MBF_FIX_LEN)
				exc = `MBF_EXC_VALUE;
			else if (!fits(w1, 16'h0001))
				exc = `MBF_EXC_ADDR;
		end else if (isDiag) begin
			if (w1 != `MBF_SUB_ECHO && w1 != `MBF_SUB_DREG) // RL4
				exc = `MBF_EXC_FUNC; // RL10
			else if (!isEcho && rxCnt_reg != `MBF_FIX_LEN)
				exc = `MBF_EXC_VALUE;
		end else if (isWrN) begin
			if (!mbfQtyOk(w2, `MBF_MAX_WR) || {8'h00, bc16} != {w2[14:0], 1'b0} // RL5
					|| rxCnt_reg != `MBF_WM_DATA + {1'b0, bc16})
				exc = `MBF_EXC_VALUE;
			else if (!fits(w1, w2))
				exc = `MBF_EXC_ADDR;
		end else if (isRw) begin
			if (!mbfQtyOk(w2, `MBF_MAX_RW) || !mbfQtyOk(w4, `MBF_MAX_RW) // RL6
					|| {8'h00, bc23} != {w4[14:0], 1'b0}
					|| rxCnt_reg != `MBF_RW_DATA + {1'b0, bc23})
				exc = `MBF_EXC_VALUE;
			else if (!fits(w1, w2) || !fits(w3, w4))
				exc = `MBF_EXC_ADDR;
		end else begin
			exc = `MBF_EXC_FUNC; // RL10
		end
	end

	// response length and byte selection
	wire hasExc = (excCode_reg != 8'h00);
	wire rdType = isRead || isRw; // RL2
	wire [8:0] rdBytes = {w2[7:0], 1'b0};
	wire [8:0] txLen = hasExc ? `MBF_EXC_LEN :
		(rdType ? `MBF_RD_DATA + rdBytes : (isEcho ? rxCnt_reg : `MBF_FIX_LEN));
	wire [8:0] rdPos = txIdx_reg - `MBF_RD_DATA;
	wire mbf_word_t rdAddr = w1 + {8'h00, rdPos[8:1]};
	wire mbf_word_t rdWord = regFile[rdAddr[IW-1:0]];
	wire txEnd = (txIdx_reg == txLen - 9'h001);

	always_comb begin
		txByte = rxBuf[txIdx_reg[7:0]]; // echo of the request
		if (hasExc) begin
			if (txIdx_reg == 9'h001)
				txByte = fc | `MBF_EXC_FLAG; // RL10
			else if (txIdx_reg == 9'h002)
				txByte = excCode_reg;
		end else if (rdType) begin
			if (txIdx_reg == 9'h002)
				txByte = rdBytes[7:0]; // RL1
			else if (txIdx_reg >= `MBF_RD_DATA)
				txByte = rdPos[0] ? rdWord[7:0] : rdWord[15:8];
		end else if (isDiag && !isEcho) begin
			if (txIdx_reg == 9'h004)
				txByte = diagWord[15:8]; // RL4
			else if (txIdx_reg == 9'h005)
				txByte = diagWord[7:0];
		end
	end

	// sequencing of receive, check, write, wait and send
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			DEV_RX: begin
				if (link.reqValid && link.reqLast)
					state_next = DEV_CHECK;
			end
			DEV_CHECK: begin
				if (!forMe || (isBcast && !bcastOk)) // RL8
					state_next = DEV_RX;
				else if (doWrite)
					state_next = DEV_WRITE;
				else
					state_next = isBcast ? DEV_RX : DEV_WAIT; // RL11
			end
			DEV_WRITE: begin
				if (wrDone)
					state_next = isBcast ? DEV_RX : DEV_WAIT; // RL11
			end
			DEV_WAIT: begin
				if (dly_reg >= DW'(RSP_CYC - 1)) // RL9
					state_next = DEV_SEND;
			end
			DEV_SEND: begin
				if (txEnd)
					state_next = DEV_RX;
			end
		endcase
	end

	// state, receive buffer and counters
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= DEV_RX;
			rxCnt_reg <= 9'h000;
			dly_reg <= '0;
			txIdx_reg <= 9'h000;
			wrIdx_reg <= 8'h00;
			excCode_reg <= 8'h00;
			for (int i = 0; i < 256; i++)
				rxBuf[i] <= 8'h00;
		end else begin
			state_reg <= state_next;
			if (state_reg == DEV_RX && link.reqValid && rxCnt_reg < `MBF_BUF_LEN) begin
				rxBuf[rxCnt_reg[7:0]] <= link.reqData;
				rxCnt_reg <= rxCnt_reg + 9'h001;
			end else if (state_reg != DEV_RX && state_next == DEV_RX) begin
				rxCnt_reg <= 9'h000;
			end
			// saturate so long write bursts cannot wrap the delay count
			dly_reg <= (state_reg == DEV_RX) ? '0 :
				((dly_reg >= DW'(RSP_CYC - 1)) ? dly_reg : dly_reg + DW'(1)); // RL9
			wrIdx_reg <= (state_reg == DEV_WRITE) ? wrIdx_reg + 8'h01 : 8'h00;
			txIdx_reg <= (state_reg == DEV_SEND) ? txIdx_reg + 9'h001 : 9'h000;
			if (state_reg == DEV_CHECK)
				excCode_reg <= exc;
		end
	end

	// register file writes, one word per cycle before any read
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < REG_COUNT; i++)
				regFile[i] <= 16'h0000;
		end else if (state_reg == DEV_WRITE) begin
			regFile[wrAddr[IW-1:0]] <= wrWord; // RL3 RL5 RL7
		end
	end

	// registered link and event outputs
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rspValid_reg <= 1'b0;
			rspData_reg <= 8'h00;
			rspLast_reg <= 1'b0;
			regWrPulse_reg <= 1'b0;
			regWrAddr_reg <= 16'h0000;
			regWrData_reg <= 16'h0000;
		end else begin
			rspValid_reg <= (state_reg == DEV_SEND);
			rspData_reg <= (state_reg == DEV_SEND) ? txByte : 8'h00;
			rspLast_reg <= (state_reg == DEV_SEND) && txEnd;
			regWrPulse_reg <= (state_reg == DEV_WRITE);
			if (state_reg == DEV_WRITE) begin
				regWrAddr_reg <= wrAddr;
				regWrData_reg <= wrWord;
			end
		end
	end

	assign link.rspValid = rspValid_reg;
	assign link.rspData = rspData_reg;
	assign link.rspLast = rspLast_reg;
	assign regWrPulse = regWrPulse_reg;
	assign regWrAddr = regWrAddr_reg;
	assign regWrData = regWrData_reg;
endmodule : mbf_dev_end

/* hdl/mbf_mst_end.sv */
`timescale 1ns/10ps
`include "mbf_defines.svh"
module mbf_mst_end #(
	parameter int TMO_CYC = `MBF_TMO_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// link to the device
	mbf_link_if.mst link,
	// command
	input wire logic cmdValid,
	input wire mbf_pkg::mbf_byte_t cmdSlave,
	input wire mbf_pkg::mbf_byte_t cmdFc,
	input wire mbf_pkg::mbf_word_t cmdStart,
	input wire mbf_pkg::mbf_word_t cmdQty,
	input wire mbf_pkg::mbf_word_t cmdWrStart,
	input wire mbf_pkg::mbf_word_t cmdWrQty,
	input wire mbf_pkg::mbf_word_t cmdValue,
	output logic cmdReady,
	output logic cmdRefused,
	// write data, word wrIdx presented on wrData
	output logic [7:0] wrIdx,
	input wire mbf_pkg::mbf_word_t wrData,
	// response bytes
	output logic rspValid,
	output mbf_pkg::mbf_byte_t rspData,
	output logic rspLast,
	output logic rspTimeout
);
	import mbf_pkg::*;
	localparam int TW = $clog2(TMO_CYC + 1);

	mbf_mst_state_t state_reg, state_next;
	mbf_byte_t slv_reg, fc_reg;
	mbf_word_t start_reg, qty_reg, wrStart_reg, wrQty_reg, value_reg;
	logic [8:0] txIdx_reg;
	logic [7:0] wrIdx_reg;
	logic [TW-1:0] tmo_reg;
	logic reqValid_reg, reqLast_reg, ready_reg, refused_reg;
	logic rspValid_reg, rspLast_reg, timeout_reg;
	mbf_byte_t reqData_reg, rspData_reg, txByte;

	// command legality, limits and broadcast
	wire cRd = (cmdFc == `MBF_FC_RD_HOLD) || (cmdFc == `MBF_FC_RD_INPUT);
	wire cWrN = (cmdFc == `MBF_FC_WR_MULTI);
	wire cRw = (cmdFc == `MBF_FC_RD_WR);
	wire cBcOk = (cmdFc == `MBF_FC_WR_ONE) || cWrN || cRw;
	wire qtyBad = (cRd && !mbfQtyOk(cmdQty, `MBF_MAX_RD)) // RL1
		|| (cWrN && !mbfQtyOk(cmdQty, `MBF_MAX_WR)) // RL5
		|| (cRw && (!mbfQtyOk(cmdQty, `MBF_MAX_RW) || !mbfQtyOk(cmdWrQty, `MBF_MAX_RW))); // RL6
	wire bcBad = (cmdSlave == `MBF_BCAST) && !cBcOk; // RL8
	wire take = (state_reg == MST_IDLE) && cmdValid;

	// telegram layout of the latched command
	wire isWrN = (fc_reg == `MBF_FC_WR_MULTI);
	wire isRw = (fc_reg == `MBF_FC_RD_WR);
	wire useVal = (fc_reg == `MBF_FC_WR_ONE) || (fc_reg == `MBF_FC_DIAG);
	wire mbf_word_t dataQty = isRw ? wrQty_reg : qty_reg;
	wire [8:0] bcnt = {dataQty[7:0], 1'b0};
	wire [8:0] base = isRw ? `MBF_RW_DATA : `MBF_WM_DATA;
	wire [8:0] txLen = (isWrN || isRw) ? base + bcnt : `MBF_FIX_LEN;
	wire txEnd = (txIdx_reg == txLen - 9'h001);
	wire [8:0] nextIdx = txIdx_reg + 9'h001;
	wire [8:0] nextOff = nextIdx - base;
	wire [8:0] curOff = txIdx_reg - base;
	wire mbf_word_t w45 = useVal ? value_reg : qty_reg;

	always_comb begin
		txByte = 8'h00;
		unique case (txIdx_reg)
			9'h000: txByte = slv_reg;
			9'h001: txByte = fc_reg;
			9'h002: txByte = start_reg[15:8];
			9'h003: txByte = start_reg[7:0];
			9'h004: txByte = w45[15:8];
			9'h005: txByte = w45[7:0];
			9'h006: txByte = isRw ? wrStart_reg[15:8] : bcnt[7:0];
			9'h007: txByte = isRw ? wrStart_reg[7:0] : wrData[15:8];
			9'h008: txByte = isRw ? wrQty_reg[15:8] : wrData[7:0];
			9'h009: txByte = isRw ? wrQty_reg[7:0] : wrData[15:8];
			9'h00A: txByte = isRw ? bcnt[7:0] : wrData[7:0];
			default: txByte = curOff[0] ? wrData[7:0] : wrData[15:8];
		endcase
	end

	// sequencing of command, send and wait
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			MST_IDLE: begin
				if (take && !qtyBad && !bcBad)
					state_next = MST_SEND;
			end
			MST_SEND: begin
				if (txEnd)
					state_next = (slv_reg == `MBF_BCAST) ? MST_IDLE : MST_WAIT;
			end
			MST_WAIT: begin
				if ((link.rspValid && link.rspLast) || tmo_reg >= TW'(TMO_CYC - 1))
					state_next = MST_IDLE;
			end
		endcase
	end

	// state and latched command
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= MST_IDLE;
			{slv_reg, fc_reg} <= 16'h0000;
			{start_reg, qty_reg, wrStart_reg, wrQty_reg, value_reg} <= 80'h0;
			txIdx_reg <= 9'h000;
			wrIdx_reg <= 8'h00;
			tmo_reg <= '0;
		end else begin
			state_reg <= state_next;
			if (take) begin
				{slv_reg, fc_reg} <= {cmdSlave, cmdFc};
				{start_reg, qty_reg} <= {cmdStart, cmdQty};
				{wrStart_reg, wrQty_reg, value_reg} <= {cmdWrStart, cmdWrQty, cmdValue};
			end
			txIdx_reg <= (state_reg == MST_SEND) ? nextIdx : 9'h000;
			wrIdx_reg <= (state_reg == MST_SEND && nextIdx > base) ? nextOff[8:1] : 8'h00;
			tmo_reg <= (state_reg == MST_WAIT) ? tmo_reg + TW'(1) : '0;
		end
	end

	// registered link and user outputs
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			{reqValid_reg, reqLast_reg, reqData_reg} <= 10'h000;
			{ready_reg, refused_reg} <= 2'b00;
			{rspValid_reg, rspLast_reg, rspData_reg, timeout_reg} <= 11'h000;
		end else begin
			reqValid_reg <= (state_reg == MST_SEND);
			reqData_reg <= (state_reg == MST_SEND) ? txByte : 8'h00;
			reqLast_reg <= (state_reg == MST_SEND) && txEnd;
			ready_reg <= (state_next == MST_IDLE);
			refused_reg <= take && (qtyBad || bcBad); // RL8
			rspValid_reg <= (state_reg == MST_WAIT) && link.rspValid;
			rspData_reg <= link.rspData;
			rspLast_reg <= (state_reg == MST_WAIT) && link.rspValid && link.rspLast;
			timeout_reg <= (state_reg == MST_WAIT) && !link.rspValid
				&& tmo_reg >= TW'(TMO_CYC - 1);
		end
	end

	assign link.reqValid = reqValid_reg;
	assign link.reqData = reqData_reg;
	assign link.reqLast = reqLast_reg;
	assign cmdReady = ready_reg;
	assign cmdRefused = refused_reg;
	assign wrIdx = wrIdx_reg;
	assign rspValid = rspValid_reg;
	assign rspData = rspData_reg;
	assign rspLast = rspLast_reg;
	assign rspTimeout = timeout_reg;
endmodule : mbf_mst_end

/* tb/mbf_link_properties.sv */
`timescale 1ns/10ps
module mbf_link_properties #(
	parameter int RSP_CYC = 120000
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// request bytes
	input wire logic reqValid,
	input wire logic [7:0] reqData,
	input wire logic reqLast,
	// response bytes
	input wire logic rspValid,
	input wire logic [7:0] rspData,
	input wire logic rspLast
);
	logic [8:0] reqIdx_reg;
	logic [8:0] rspIdx_reg;
	logic [7:0] reqAddr_reg;
	logic [7:0] reqFc_reg;
	logic [17:0] since_reg;
	logic bcast_reg;
	wire logic rspStart = rspValid && (rspIdx_reg == 9'h000);
	// byte positions, station, code and time since request end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reqIdx_reg <= 9'h000;
			rspIdx_reg <= 9'h000;
			reqAddr_reg <= 8'h00;
			reqFc_reg <= 8'h00;
			since_reg <= 18'h00000;
			bcast_reg <= 1'b0;
		end else begin
			if (reqValid) reqIdx_reg <= reqLast ? 9'h000 : reqIdx_reg + 9'h001;
			if (reqValid && reqIdx_reg == 9'h000) reqAddr_reg <= reqData;
			if (reqValid && reqIdx_reg == 9'h001) reqFc_reg <= reqData;
			if (rspValid) rspIdx_reg <= rspLast ? 9'h000 : rspIdx_reg + 9'h001;
			since_reg <= (reqValid && reqLast) ? 18'h00000 : since_reg + 18'h00001;
			if (reqValid) bcast_reg <= reqLast && (reqAddr_reg == 8'h00);
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	chk_last_with_valid: assert property (reqLast |-> reqValid)
		else $error("request end flag without byte");
	chk_rsp_last_valid: assert property (rspLast |-> rspValid)
		else $error("response end flag without byte");
	chk_rsp_delay_window: assert property (
		rspStart |-> since_reg >= RSP_CYC && since_reg <= RSP_CYC * 5 / 3)
		else $error("response start outside delay window");
	chk_rsp_back_to_back: assert property (rspValid && !rspLast |=> rspValid)
		else $error("gap inside response");
	chk_rsp_station: assert property (rspStart |-> rspData == reqAddr_reg)
		else $error("response station differs from request");
	chk_rsp_code_echo: assert property ((rspValid && rspIdx_reg == 9'h001) |->
		rspData == reqFc_reg || rspData == (reqFc_reg | 8'h80))
		else $error("response code unrelated to request");
	chk_exc_three_bytes: assert property (
		(rspValid && rspIdx_reg == 9'h001 && rspData[7]) |=> rspValid && rspLast)
		else $error("exception answer not three bytes");
	chk_bcast_silent: assert property (bcast_reg |-> !rspValid)
		else $error("answer to broadcast");
	chk_no_overlap: assert property (rspValid |-> !reqValid)
		else $error("request sent during response");
endmodule : mbf_link_properties

/* tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
	import mbf_pkg::*;
	localparam int RSP = 200;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic cmdValid = 1'b0;
	mbf_byte_t cmdSlave = 8'h00, cmdFc = 8'h00, ownAddr = 8'h01;
	mbf_word_t cmdStart = 16'h0000, cmdQty = 16'h0000, cmdWrStart = 16'h0000;
	mbf_word_t cmdWrQty = 16'h0000, cmdValue = 16'h0000, diagWord = 16'h5A3C;
	logic cmdReady, cmdRefused, rspValid, rspLast, rspTimeout, regWrPulse;
	logic [7:0] wrIdx;
	mbf_byte_t rspData;
	mbf_word_t regWrAddr, regWrData;
	wire mbf_word_t wrData = {8'hA5, wrIdx};
	logic [7:0] rspQ[$], rsp2Q[$];
	logic [31:0] wrQ[$];
	logic refSeen = 1'b0;
	int nErrors = 0;
	int samplesChecked = 0;
	int lastPos = 0;
	int tmoCount = 0;
	mbf_link_if link1();
	mbf_link_if link2();
	always #12.5 clk = ~clk;
	// both ends, a second device for far-side faults, and the checker
	mbf_dev_end #(.REG_COUNT(128), .RSP_CYC(RSP)) mbf_dev_end_inst (.clk(clk), .rst_b(rst_b),
		.link(link1.dev), .ownAddr(ownAddr), .diagWord(diagWord), .regWrPulse(regWrPulse),
		.regWrAddr(regWrAddr), .regWrData(regWrData));
	mbf_dev_end #(.REG_COUNT(128), .RSP_CYC(RSP)) mbf_dev_end_inst_b (.clk(clk), .rst_b(rst_b),
		.link(link2.dev), .ownAddr(ownAddr), .diagWord(diagWord), .regWrPulse(),
		.regWrAddr(), .regWrData());
	mbf_mst_end #(.TMO_CYC(1000)) mbf_mst_end_inst (.clk(clk), .rst_b(rst_b), .link(link1.mst),
		.cmdValid(cmdValid), .cmdSlave(cmdSlave), .cmdFc(cmdFc), .cmdStart(cmdStart),
		.cmdQty(cmdQty), .cmdWrStart(cmdWrStart), .cmdWrQty(cmdWrQty), .cmdValue(cmdValue),
		.cmdReady(cmdReady), .cmdRefused(cmdRefused), .wrIdx(wrIdx), .wrData(wrData),
		.rspValid(rspValid), .rspData(rspData), .rspLast(rspLast), .rspTimeout(rspTimeout));
	mbf_link_properties #(.RSP_CYC(RSP)) mbf_link_properties_inst (.clk(clk), .rst_b(rst_b),
		.reqValid(link1.reqValid), .reqData(link1.reqData), .reqLast(link1.reqLast),
		.rspValid(link1.rspValid), .rspData(link1.rspData), .rspLast(link1.rspLast));
	// gather answers and write events
	always @(posedge clk) begin
		if (rspValid === 1'b1 && rspLast === 1'b1) lastPos = rspQ.size() + 1;
		if (rspValid === 1'b1) rspQ.push_back(rspData);
		if (rspTimeout === 1'b1) tmoCount++;
		if (link2.rspValid === 1'b1) rsp2Q.push_back(link2.rspData);
		if (regWrPulse === 1'b1) wrQ.push_back({regWrAddr, regWrData});
		if (cmdRefused === 1'b1) refSeen = 1'b1;
	end
	task automatic completeRun();
		if (nErrors == 0 && samplesChecked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : completeRun
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			nErrors++;
			$display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : cmp
	task automatic expBytes(input logic [7:0] e[$], input logic [7:0] g[$]);
		cmp(g.size(), e.size());
		foreach (e[i]) cmp(g[i], e[i]);
	endtask : expBytes
	// wait for an idle master, bounded
	task automatic waitIdle();
		int n;
		n = 0;
		while (cmdReady !== 1'b1) begin
			@(posedge clk);
			#1;
			n++;
			if (n > 1500) begin
				nErrors++;
				completeRun();
			end
		end
	endtask : waitIdle
	task automatic issue(input logic [7:0] sl, fc, input logic [15:0] st, qt, ws, wq, va);
		waitIdle();
		rspQ.delete();
		wrQ.delete();
		refSeen = 1'b0;
		lastPos = 0;
		@(posedge clk);
		cmdValid <= 1'b1;
		cmdSlave <= sl;
		cmdFc <= fc;
		cmdStart <= st;
		cmdQty <= qt;
		cmdWrStart <= ws;
		cmdWrQty <= wq;
		cmdValue <= va;
		@(posedge clk);
		cmdValid <= 1'b0;
		#1;
		waitIdle();
		// room for broadcast writes that trail the end of the telegram
		repeat (5) @(posedge clk);
		#1;
	endtask : issue
	// telegram sent straight into the second device
	task automatic raw(input logic [7:0] b[$]);
		rsp2Q.delete();
		foreach (b[i]) begin
			@(posedge clk);
			link2.reqValid <= 1'b1;
			link2.reqData <= b[i];
			link2.reqLast <= (i == b.size() - 1);
		end
		@(posedge clk);
		link2.reqValid <= 1'b0;
		link2.reqLast <= 1'b0;
		link2.reqData <= ~b[b.size() - 1];
		repeat (RSP + 30) @(posedge clk);
		#1;
	endtask : raw
	task automatic sWrites();
		issue(8'h01, 8'h06, 16'h0005, 16'h0000, 16'h0000, 16'h0000, 16'h1234);
		expBytes('{8'h01, 8'h06, 8'h00, 8'h05, 8'h12, 8'h34}, rspQ);
		cmp(lastPos, 6);
		cmp(wrQ.size(), 1);
		cmp(wrQ[0], 32'h00051234);
		issue(8'h01, 8'h10, 16'h0008, 16'h0078, 16'h0000, 16'h0000, 16'h0000);
		expBytes('{8'h01, 8'h10, 8'h00, 8'h08, 8'h00, 8'h78}, rspQ);
		cmp(wrQ.size(), 120);
		for (int i = 0; i < 120; i++) cmp(wrQ[i], {16'(8 + i), 8'hA5, 8'(i)});
		issue(8'h01, 8'h10, 16'h0008, 16'h0079, 16'h0000, 16'h0000, 16'h0000);
		cmp(refSeen, 1'b1);
	endtask : sWrites
	task automatic sReads();
		logic [7:0] e[$];
		logic [7:0] fcs[2] = '{8'h03, 8'h04};
		foreach (fcs[k]) begin
			issue(8'h01, fcs[k], 16'h0000, 16'h007D, 16'h0000, 16'h0000, 16'h0000);
			e = '{8'h01, fcs[k], 8'hFA};
			for (int r = 0; r < 125; r++) begin
				e.push_back(r == 5 ? 8'h12 : (r >= 8 ? 8'hA5 : 8'h00));
				e.push_back(r == 5 ? 8'h34 : (r >= 8 ? 8'(r - 8) : 8'h00));
			end
			expBytes(e, rspQ);
			cmp(lastPos, 253);
		end
		issue(8'h01, 8'h03, 16'h0000, 16'h007E, 16'h0000, 16'h0000, 16'h0000);
		cmp(refSeen, 1'b1);
		issue(8'h01, 8'h04, 16'h0078, 16'h000A, 16'h0000, 16'h0000, 16'h0000);
		expBytes('{8'h01, 8'h84, 8'h02}, rspQ);
	endtask : sReads
	task automatic sReadWrite();
		issue(8'h01, 8'h17, 16'h0000, 16'h0002, 16'h0000, 16'h0002, 16'h0000);
		expBytes('{8'h01, 8'h17, 8'h04, 8'hA5, 8'h00, 8'hA5, 8'h01}, rspQ);
		issue(8'h01, 8'h17, 16'h0001, 16'h0001, 16'h0008, 16'h0076, 16'h0000);
		expBytes('{8'h01, 8'h17, 8'h02, 8'hA5, 8'h01}, rspQ);
		cmp(wrQ.size(), 118);
		issue(8'h01, 8'h17, 16'h0000, 16'h0077, 16'h0000, 16'h0001, 16'h0000);
		cmp(refSeen, 1'b1);
		issue(8'h01, 8'h17, 16'h0000, 16'h0001, 16'h0000, 16'h0077, 16'h0000);
		cmp(refSeen, 1'b1);
	endtask : sReadWrite
	task automatic sDiag();
		issue(8'h01, 8'h08, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hBEEF);
		expBytes('{8'h01, 8'h08, 8'h00, 8'h00, 8'hBE, 8'hEF}, rspQ);
		issue(8'h01, 8'h08, 16'h0002, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
		expBytes('{8'h01, 8'h08, 8'h00, 8'h02, 8'h5A, 8'h3C}, rspQ);
		issue(8'h01, 8'h08, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
		expBytes('{8'h01, 8'h88, 8'h01}, rspQ);
		issue(8'h01, 8'h05, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
		expBytes('{8'h01, 8'h85, 8'h01}, rspQ);
	endtask : sDiag
	task automatic sBcast();
		issue(8'h00, 8'h06, 16'h0003, 16'h0000, 16'h0000, 16'h0000, 16'h0BCD);
		cmp(rspQ.size(), 0);
		cmp(wrQ.size(), 1);
		cmp(wrQ[0], 32'h00030BCD);
		issue(8'h00, 8'h03, 16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000);
		cmp(refSeen, 1'b1);
		raw('{8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01});
		cmp(rsp2Q.size(), 0);
		raw('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h7E});
		expBytes('{8'h01, 8'h83, 8'h03}, rsp2Q);
		// foreign station: no answer, master must time out exactly once in the run
		issue(8'h02, 8'h03, 16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000);
		cmp(rspQ.size(), 0);
		cmp(tmoCount, 1);
	endtask : sBcast
	// reset, then each scenario in turn
	initial begin
		link2.reqValid = 1'b0;
		link2.reqData = 8'h00;
		link2.reqLast = 1'b0;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		sWrites();
		sReads();
		sReadWrite();
		sDiag();
		sBcast();
		completeRun();
	end
endmodule : tb_top
